// ===== tps_master.sv
// dictionary master model for the tilt position scaling block
module tps_master
(
  input wire logic clk,
  output logic od_req,
  output logic od_we,
  output logic [15:0] od_index,
  output logic [15:0] od_wdata,
  input wire logic od_ack_q,
  input wire logic od_err_q,
  input wire logic [15:0] od_rdata_q
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    od_req = 1'b0;
    od_we = 1'b0;
    od_index = 16'h0000;
    od_wdata = 16'h0000;
  end

  // ==========================================================
  // one access: request for one edge, answer one cycle later
  task automatic access(input logic we, input logic [15:0] idx, input logic [15:0] wd,
    output logic ack, output logic err, output logic [15:0] rd);
    @(posedge clk);
    od_req <= 1'b1;
    od_we <= we;
    od_index <= idx;
    od_wdata <= wd;
    @(posedge clk);
    od_req <= 1'b0;
    // released lines must not keep showing the last request
    od_index <= ~idx;
    od_wdata <= ~wd;
    @(negedge clk);
    ack = od_ack_q;
    err = od_err_q;
    rd = od_rdata_q;
  endtask : access

endmodule : tps_master

// ===== tps_pkg.sv
// constants shared by the tilt position scaling block
package tps_pkg;

  // ==========================================================
  // object dictionary indices
  localparam logic [15:0] TPS_IDX_RES = 16'h6000;
  localparam logic [15:0] TPS_IDX_LONG_VAL = 16'h6010;
  localparam logic [15:0] TPS_IDX_LONG_OP = 16'h6011;
  localparam logic [15:0] TPS_IDX_LONG_PRESET = 16'h6012;
  localparam logic [15:0] TPS_IDX_LONG_OFS = 16'h6013;
  localparam logic [15:0] TPS_IDX_LONG_DIFF = 16'h6014;
  localparam logic [15:0] TPS_IDX_LAT_VAL = 16'h6020;
  localparam logic [15:0] TPS_IDX_LAT_OP = 16'h6021;
  localparam logic [15:0] TPS_IDX_LAT_PRESET = 16'h6022;
  localparam logic [15:0] TPS_IDX_LAT_OFS = 16'h6023;
  localparam logic [15:0] TPS_IDX_LAT_DIFF = 16'h6024;
  localparam logic [15:0] TPS_IDX_LONG_PRESET_W = 16'h6112;
  localparam logic [15:0] TPS_IDX_LAT_PRESET_W = 16'h6122;
  localparam logic [15:0] TPS_IDX_PRESET_X = 16'h2600;
  localparam logic [15:0] TPS_IDX_PRESET_Y = 16'h2601;

  // ==========================================================
  // resolution codes and scaling
  localparam logic [15:0] TPS_RES_CODE_1 = 16'h0001;
  localparam logic [15:0] TPS_RES_CODE_0_1 = 16'h0002;
  localparam logic [15:0] TPS_RES_CODE_0_01 = 16'h000A;
  localparam logic [15:0] TPS_RES_RESET = 16'h000A;
  localparam logic signed [15:0] TPS_SCALE_1 = 16'sh0064;
  localparam logic signed [15:0] TPS_SCALE_0_1 = 16'sh000A;
  localparam logic signed [15:0] TPS_SCALE_0_01 = 16'sh0001;
  // all angles are kept internally in 0.01 degree steps
  localparam logic signed [15:0] TPS_LIMIT_FINE = 16'sh1F40;

  typedef enum logic [1:0] {
    TPS_RES_1 = 2'b00,
    TPS_RES_0_1 = 2'b01,
    TPS_RES_0_01 = 2'b10
  } tps_res_e;

  // ==========================================================
  // operating parameter layout and two's complement base
  localparam int TPS_OP_INV_BIT = 0;
  localparam int TPS_OP_SCL_BIT = 1;
  localparam logic [7:0] TPS_OP_RESET = 8'h00;
  localparam logic [16:0] TPS_TWO_C16 = 17'h10000;
  localparam logic [15:0] TPS_ZERO16 = 16'h0000;

endpackage : tps_pkg

// ===== tps_scaling.sv
// tilt position scaling: per-axis arithmetic and object dictionary access

// ==========================================================
// one axis: inversion, offsets, clamp
module tps_axis
  import tps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic signed [15:0] phys_i,
  input wire logic sample_i,
  input wire logic [7:0] op_i,
  input wire logic preset_we,
  input wire logic diff_we,
  input wire logic signed [15:0] wfine,
  output logic signed [15:0] tilt_fine_q,
  output logic signed [15:0] offset_q,
  output logic signed [15:0] preset_q,
  output logic signed [15:0] diff_q
);
  logic signed [15:0] phys_q;
  logic signed [15:0] x_mul;
  logic signed [15:0] sum_d;
  logic signed [15:0] tilt_d;
  logic [16:0] neg_w;

  function automatic logic signed [15:0] clampf(input logic signed [15:0] v);
    if (v > TPS_LIMIT_FINE)
      return TPS_LIMIT_FINE;
    else if (v < -TPS_LIMIT_FINE)
      return -TPS_LIMIT_FINE;
    else
      return v;
  endfunction : clampf

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      phys_q <= '0;
    else if (sample_i)
      phys_q <= phys_i;
  end

  always_comb
  begin
    neg_w = TPS_TWO_C16 - {1'b0, phys_q};
    x_mul = op_i[TPS_OP_INV_BIT] ? $signed(neg_w[15:0]) : phys_q;
    // sum wraps in 16 bits, as the counts do
    sum_d = op_i[TPS_OP_SCL_BIT] ? x_mul + offset_q + diff_q : x_mul;
    tilt_d = clampf(sum_d);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tilt_fine_q <= '0;
    else
      tilt_fine_q <= tilt_d;
  end

  // offset latches the sample present at preset time
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      preset_q <= '0;
      offset_q <= '0;
    end
    else if (preset_we)
    begin
      preset_q <= wfine;
      offset_q <= wfine - x_mul;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      diff_q <= '0;
    else if (diff_we)
      diff_q <= wfine;
  end

  plain_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    (op_i[1:0] == 2'b00 && $stable(op_i) && $stable(phys_q)) |-> tilt_fine_q == clampf(phys_q))
    else $error("plain output differs from inclination");
  invert_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    (op_i[1:0] == 2'b01 && $stable(op_i) && $stable(phys_q))
      |-> tilt_fine_q == clampf(-phys_q))
    else $error("inverted output wrong");
  scaled_sum_a: assert property (@(posedge clk) disable iff (!rst_n)
    (op_i[1:0] == 2'b10 && $stable(op_i) && $stable(phys_q) && !preset_we && !diff_we
      && !$past(preset_we) && !$past(diff_we))
      |-> tilt_fine_q == clampf(phys_q + offset_q + diff_q))
    else $error("scaled output is not sum of offsets");
  offset_calc_a: assert property (@(posedge clk) disable iff (!rst_n)
    preset_we ##1 1'b1 |-> offset_q == $past(wfine) - $past(x_mul)
      && preset_q == $past(wfine))
    else $error("offset not preset minus captured inclination");
  diff_store_a: assert property (@(posedge clk) disable iff (!rst_n)
    diff_we |=> diff_q == $past(wfine) ##1 ($past(diff_we) || $stable(diff_q)))
    else $error("differential offset not stored");

endmodule : tps_axis

// ==========================================================
// top: resolution, operating bytes, dictionary access
// Overview of operation
// - resolution setting is 16-bit read/write, default 10 meaning 0.01 degree.
// - longitudinal tilt is read-only signed 16-bit, limited per resolution.
// - lateral tilt is read-only signed 16-bit, limited per resolution.
// - changing resolution rescales presets, offsets and tilts; rounding accepted.
// - longitudinal operating bit 0 negates the inclination before offsets.
// - longitudinal operating bit 1 adds computed and differential offsets.
// - both bits may be set; both clear gives the raw inclination.
// - inversion is two's complement, 10000h minus the value.
// - longitudinal offset recomputed on any longitudinal preset write.
// - offset is preset minus captured inclination times the inversion multiplier.
// - longitudinal offset is read-only signed 16-bit.
// - differential longitudinal offset is writable, added only while scaling.
// - longitudinal preset signed 16-bit, default 0, range limited per resolution.
// - lateral operating byte, default 00, bit 0 inverts, bit 1 adds offsets.
// - lateral scaled output is inclination times multiplier plus both offsets.
// - lateral offset is lateral preset minus captured inclination times multiplier.
// - lateral offset recomputed on any lateral preset write.
module tps_scaling
  import tps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic signed [15:0] phys_long,
  input wire logic signed [15:0] phys_lat,
  input wire logic sample_valid,
  input wire logic od_req,
  input wire logic od_we,
  input wire logic [15:0] od_index,
  input wire logic [15:0] od_wdata,
  output logic od_ack_q,
  output logic od_err_q,
  output logic [15:0] od_rdata_q,
  output logic signed [15:0] longitudinal_tilt_q,
  output logic signed [15:0] lateral_tilt_q
);
  import tps_pkg::*;

  logic [15:0] res_q;
  logic [7:0] long_op_q;
  logic [7:0] lat_op_q;
  tps_res_e sel;
  logic signed [15:0] wfine;
  logic signed [15:0] lim_cur;
  logic preset_ok;
  logic wr;
  logic long_pre_we;
  logic lat_pre_we;
  logic long_diff_we;
  logic lat_diff_we;
  logic res_we;
  logic res_ok;
  logic signed [15:0] long_fine;
  logic signed [15:0] long_ofs;
  logic signed [15:0] long_pre;
  logic signed [15:0] long_diff;
  logic signed [15:0] lat_fine;
  logic signed [15:0] lat_ofs;
  logic signed [15:0] lat_pre;
  logic signed [15:0] lat_diff;
  logic [15:0] rdata_d;
  logic err_d;

  function automatic logic signed [15:0] scale_of(input tps_res_e s);
    case (s)
      TPS_RES_1: return TPS_SCALE_1;
      TPS_RES_0_1: return TPS_SCALE_0_1;
      default: return TPS_SCALE_0_01;
    endcase
  endfunction : scale_of

  // truncation toward zero is the rounding loss on coarse settings
  function automatic logic signed [15:0] from_fine(input logic signed [15:0] v,
                                                   input tps_res_e s);
    return v / scale_of(s);
  endfunction : from_fine

  function automatic logic signed [15:0] to_fine(input logic signed [15:0] v,
                                                 input tps_res_e s);
    logic signed [31:0] p;
    p = v * scale_of(s);
    return p[15:0];
  endfunction : to_fine

  // ==========================================================
  // decode
  always_comb
  begin
    case (res_q)
      TPS_RES_CODE_1: sel = TPS_RES_1;
      TPS_RES_CODE_0_1: sel = TPS_RES_0_1;
      default: sel = TPS_RES_0_01;
    endcase
    res_ok = (od_wdata == TPS_RES_CODE_1) || (od_wdata == TPS_RES_CODE_0_1)
             || (od_wdata == TPS_RES_CODE_0_01);
    wfine = to_fine($signed(od_wdata), sel);
    lim_cur = from_fine(TPS_LIMIT_FINE, sel);
    preset_ok = ($signed(od_wdata) <= lim_cur) && ($signed(od_wdata) >= -lim_cur);
    wr = od_req && od_we;
    res_we = wr && od_index == TPS_IDX_RES && res_ok;
    long_pre_we = wr && preset_ok && (od_index == TPS_IDX_LONG_PRESET
                  || od_index == TPS_IDX_LONG_PRESET_W || od_index == TPS_IDX_PRESET_X);
    lat_pre_we = wr && preset_ok && (od_index == TPS_IDX_LAT_PRESET
                 || od_index == TPS_IDX_LAT_PRESET_W || od_index == TPS_IDX_PRESET_Y);
    long_diff_we = wr && od_index == TPS_IDX_LONG_DIFF;
    lat_diff_we = wr && od_index == TPS_IDX_LAT_DIFF;
  end

  // ==========================================================
  // settings
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      res_q <= TPS_RES_RESET;
    else if (res_we)
      res_q <= od_wdata;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      long_op_q <= TPS_OP_RESET;
      lat_op_q <= TPS_OP_RESET;
    end
    else if (wr && od_index == TPS_IDX_LONG_OP)
      long_op_q <= od_wdata[7:0];
    else if (wr && od_index == TPS_IDX_LAT_OP)
      lat_op_q <= od_wdata[7:0];
  end

  tps_axis u_long (
    .clk(clk),
    .rst_n(rst_n),
    .phys_i(phys_long),
    .sample_i(sample_valid),
    .op_i(long_op_q),
    .preset_we(long_pre_we),
    .diff_we(long_diff_we),
    .wfine(wfine),
    .tilt_fine_q(long_fine),
    .offset_q(long_ofs),
    .preset_q(long_pre),
    .diff_q(long_diff)
  );

  tps_axis u_lat (
    .clk(clk),
    .rst_n(rst_n),
    .phys_i(phys_lat),
    .sample_i(sample_valid),
    .op_i(lat_op_q),
    .preset_we(lat_pre_we),
    .diff_we(lat_diff_we),
    .wfine(wfine),
    .tilt_fine_q(lat_fine),
    .offset_q(lat_ofs),
    .preset_q(lat_pre),
    .diff_q(lat_diff)
  );

  // ==========================================================
  // reported tilts in the current resolution
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      longitudinal_tilt_q <= '0;
      lateral_tilt_q <= '0;
    end
    else
    begin
      longitudinal_tilt_q <= from_fine(long_fine, sel);
      lateral_tilt_q <= from_fine(lat_fine, sel);
    end
  end

  // ==========================================================
  // dictionary read and answer
  always_comb
  begin
    rdata_d = TPS_ZERO16;
    err_d = 1'b0;
    case (od_index)
      TPS_IDX_RES: err_d = od_we && !res_ok;
      TPS_IDX_LONG_VAL: begin rdata_d = longitudinal_tilt_q; err_d = od_we; end
      TPS_IDX_LAT_VAL: begin rdata_d = lateral_tilt_q; err_d = od_we; end
      TPS_IDX_LONG_OP, TPS_IDX_LAT_OP: err_d = 1'b0;
      TPS_IDX_LONG_PRESET, TPS_IDX_LONG_PRESET_W, TPS_IDX_PRESET_X:
      begin
        rdata_d = from_fine(long_pre, sel);
        err_d = od_we && !preset_ok;
      end
      TPS_IDX_LAT_PRESET, TPS_IDX_LAT_PRESET_W, TPS_IDX_PRESET_Y:
      begin
        rdata_d = from_fine(lat_pre, sel);
        err_d = od_we && !preset_ok;
      end
      TPS_IDX_LONG_OFS: begin rdata_d = from_fine(long_ofs, sel); err_d = od_we; end
      TPS_IDX_LAT_OFS: begin rdata_d = from_fine(lat_ofs, sel); err_d = od_we; end
      TPS_IDX_LONG_DIFF: rdata_d = from_fine(long_diff, sel);
      TPS_IDX_LAT_DIFF: rdata_d = from_fine(lat_diff, sel);
      default: err_d = 1'b1;
    endcase
    if (od_index == TPS_IDX_RES)
      rdata_d = res_q;
    else if (od_index == TPS_IDX_LONG_OP)
      rdata_d = {8'h00, long_op_q};
    else if (od_index == TPS_IDX_LAT_OP)
      rdata_d = {8'h00, lat_op_q};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      od_ack_q <= 1'b0;
      od_err_q <= 1'b0;
      od_rdata_q <= '0;
    end
    else
    begin
      od_ack_q <= od_req;
      od_err_q <= od_req && err_d;
      od_rdata_q <= od_req ? rdata_d : TPS_ZERO16;
    end
  end

  res_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    res_we |=> res_q == $past(od_wdata))
    else $error("resolution write not taken");
  res_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && od_index == TPS_IDX_RES && !res_ok) |=> $stable(res_q) && od_err_q)
    else $error("bad resolution code accepted");
  long_limit_a: assert property (@(posedge clk) disable iff (!rst_n)
    longitudinal_tilt_q <= from_fine(TPS_LIMIT_FINE, sel)
      && longitudinal_tilt_q >= -from_fine(TPS_LIMIT_FINE, sel)
      || $changed(res_q))
    else $error("longitudinal tilt beyond limit");
  lat_limit_a: assert property (@(posedge clk) disable iff (!rst_n)
    ($stable(res_q) |-> lateral_tilt_q <= from_fine(TPS_LIMIT_FINE, sel)
      && lateral_tilt_q >= -from_fine(TPS_LIMIT_FINE, sel)))
    else $error("lateral tilt beyond limit");
  rescale_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(res_q) ##1 $stable(res_q) |-> longitudinal_tilt_q == from_fine($past(long_fine), sel))
    else $error("tilt not rescaled");
  preset_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && od_index == TPS_IDX_LONG_PRESET && !preset_ok) |=> od_err_q && $stable(long_pre))
    else $error("out of range preset accepted");

endmodule : tps_scaling

// ===== tps_scaling_tb.sv
// self-checking bench for the tilt position scaling block
module tps_scaling_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tps_pkg::*;

  logic clk;
  logic rst_n;
  logic signed [15:0] phys_long;
  logic signed [15:0] phys_lat;
  logic sample_valid;
  logic od_req;
  logic od_we;
  logic [15:0] od_index;
  logic [15:0] od_wdata;
  logic od_ack_q;
  logic od_err_q;
  logic [15:0] od_rdata_q;
  logic signed [15:0] longitudinal_tilt_q;
  logic signed [15:0] lateral_tilt_q;
  int errors;
  int checked;
  logic ack;
  logic err;
  logic [15:0] rd;

  tps_scaling i_tps_scaling (.clk(clk), .rst_n(rst_n), .phys_long(phys_long),
    .phys_lat(phys_lat), .sample_valid(sample_valid), .od_req(od_req), .od_we(od_we),
    .od_index(od_index), .od_wdata(od_wdata), .od_ack_q(od_ack_q), .od_err_q(od_err_q),
    .od_rdata_q(od_rdata_q), .longitudinal_tilt_q(longitudinal_tilt_q),
    .lateral_tilt_q(lateral_tilt_q));

  tps_master i_tps_master (.clk(clk), .od_req(od_req), .od_we(od_we), .od_index(od_index),
    .od_wdata(od_wdata), .od_ack_q(od_ack_q), .od_err_q(od_err_q), .od_rdata_q(od_rdata_q));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================================
  // shared helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] idx, input logic [15:0] d, input logic e);
    i_tps_master.access(1'b1, idx, d, ack, err, rd);
    chk({14'h0000, ack, err}, {14'h0000, 1'b1, e});
  endtask : wr

  task automatic rdv(input logic [15:0] idx, input logic [15:0] v);
    i_tps_master.access(1'b0, idx, 16'h0000, ack, err, rd);
    chk({15'h0000, ack}, 16'h0001);
    chk(rd, v);
  endtask : rdv

  task automatic sample(input logic [15:0] l, input logic [15:0] a);
    @(posedge clk);
    phys_long <= l;
    phys_lat <= a;
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
  endtask : sample

  // pipeline is three cycles; one spare keeps the check off the edge
  task automatic tilt(input logic [15:0] el, input logic [15:0] ea);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk(longitudinal_tilt_q, el);
    chk(lateral_tilt_q, ea);
  endtask : tilt

  task automatic report_and_stop();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rdv(TPS_IDX_RES, TPS_RES_RESET);
    rdv(TPS_IDX_LONG_OP, 16'h0000);
    rdv(TPS_IDX_LAT_OP, 16'h0000);
    rdv(TPS_IDX_LONG_PRESET, 16'h0000);
    wr(16'h6030, 16'h0000, 1'b1);
  endtask : t_reset

  task automatic t_raw();
    sample(16'h04D2, 16'hFDC9);
    tilt(16'h04D2, 16'hFDC9);
    rdv(TPS_IDX_LONG_VAL, 16'h04D2);
    wr(TPS_IDX_RES, TPS_RES_CODE_0_1, 1'b0);
    tilt(16'h007B, 16'hFFC8);
    wr(TPS_IDX_RES, TPS_RES_CODE_1, 1'b0);
    tilt(16'h000C, 16'hFFFB);
    wr(TPS_IDX_RES, 16'h0003, 1'b1);
    wr(TPS_IDX_LONG_VAL, 16'h0000, 1'b1);
    wr(TPS_IDX_LAT_VAL, 16'h0000, 1'b1);
    wr(TPS_IDX_RES, TPS_RES_CODE_0_01, 1'b0);
  endtask : t_raw

  task automatic t_inv();
    wr(TPS_IDX_LONG_OP, 16'h0001, 1'b0);
    wr(TPS_IDX_LAT_OP, 16'h0001, 1'b0);
    tilt(16'hFB2E, 16'h0237);
    wr(TPS_IDX_LONG_OP, 16'h0000, 1'b0);
    wr(TPS_IDX_LAT_OP, 16'h0000, 1'b0);
  endtask : t_inv

  task automatic t_preset();
    sample(16'h03E8, 16'hFDC9);
    wr(TPS_IDX_LONG_OP, 16'h0002, 1'b0);
    wr(TPS_IDX_LONG_PRESET, 16'h01F4, 1'b0);
    rdv(TPS_IDX_LONG_OFS, 16'hFE0C);
    tilt(16'h01F4, 16'hFDC9);
    wr(TPS_IDX_LONG_DIFF, 16'h0019, 1'b0);
    tilt(16'h020D, 16'hFDC9);
    wr(TPS_IDX_LONG_OP, 16'h0000, 1'b0);
    tilt(16'h03E8, 16'hFDC9);
    wr(TPS_IDX_LONG_OP, 16'h0003, 1'b0);
    tilt(16'hFA3D, 16'hFDC9);
    wr(TPS_IDX_PRESET_X, 16'h0064, 1'b0);
    rdv(TPS_IDX_LONG_OFS, 16'h044C);
    tilt(16'h007D, 16'hFDC9);
    wr(TPS_IDX_LONG_PRESET_W, 16'h0000, 1'b0);
    rdv(TPS_IDX_LONG_OFS, 16'h03E8);
    wr(TPS_IDX_LONG_OFS, 16'h0000, 1'b1);
    wr(TPS_IDX_LAT_OP, 16'h0002, 1'b0);
    wr(TPS_IDX_PRESET_Y, 16'h00C8, 1'b0);
    rdv(TPS_IDX_LAT_OFS, 16'h02FF);
    tilt(16'h0019, 16'h00C8);
    wr(TPS_IDX_LAT_PRESET_W, 16'hFF9C, 1'b0);
    rdv(TPS_IDX_LAT_OFS, 16'h01D3);
    wr(TPS_IDX_RES, TPS_RES_CODE_0_1, 1'b0);
    rdv(TPS_IDX_LONG_OFS, 16'h0064);
    tilt(16'h0002, 16'hFFF6);
    wr(TPS_IDX_RES, TPS_RES_CODE_0_01, 1'b0);
  endtask : t_preset

  task automatic t_clamp();
    sample(16'h1F36, 16'hE0CA);
    wr(TPS_IDX_LONG_OP, 16'h0002, 1'b0);
    wr(TPS_IDX_LONG_PRESET, 16'h1F40, 1'b0);
    wr(TPS_IDX_LONG_DIFF, 16'h0064, 1'b0);
    tilt(16'h1F40, 16'hE29D);
    wr(TPS_IDX_LONG_PRESET, 16'h1F41, 1'b1);
    wr(TPS_IDX_RES, TPS_RES_CODE_1, 1'b0);
    wr(TPS_IDX_LONG_PRESET, 16'h0051, 1'b1);
    wr(TPS_IDX_LONG_PRESET, 16'h0050, 1'b0);
    wr(TPS_IDX_LAT_DIFF, 16'hFFFF, 1'b0);
    wr(TPS_IDX_LAT_PRESET, 16'hFFB0, 1'b0);
    tilt(16'h0050, 16'hFFB0);
    rdv(TPS_IDX_LONG_PRESET, 16'h0050);
  endtask : t_clamp

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    errors = 0;
    checked = 0;
    rst_n = 1'b0;
    phys_long = 16'sh0000;
    phys_lat = 16'sh0000;
    sample_valid = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_raw();
    t_inv();
    t_preset();
    t_clamp();
    report_and_stop();
  end

  // all scenarios need well under 1000 cycles
  initial
  begin
    #200000;
    errors++;
    report_and_stop();
  end

endmodule : tps_scaling_tb
